// [rtl/boot_opt_pkg.sv]
// Shared constants and carrier types for the bus-side option logic.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package boot_opt_pkg;

   // Clock rate
   localparam int CLK_MHZ = 100;

   // Relative port numbers within the four-port block
   localparam logic [1:0] PORT_FDC_MSR = 2'h0;
   localparam logic [1:0] PORT_FDC_DATA = 2'h1;
   localparam logic [1:0] PORT_STATUS = 2'h2;
   localparam logic [1:0] PORT_SERIAL = 2'h3;

   // Data bit positions
   localparam int BIT_IRQ = 7;
   localparam int BIT_SER = 7;
   localparam int BIT_BOOT_KEEP = 0;

   // Switch bank A positions (bit index = position - 1)
   localparam int SWA_WAIT_EN = 0;
   localparam int SWA_MOTOR_CTL = 2;
   localparam int SWA_BOOT_INH = 3;
   localparam int SWA_PRIO3 = 4;
   localparam int SWA_PRIO2 = 5;
   localparam int SWA_PRIO1 = 6;
   localparam int SWA_PRIO0 = 7;

   // Switch bank B positions
   localparam int SWB_ROUT_HI = 0;
   localparam int SWB_ROUT_LO = 1;
   localparam int SWB_BASE_A7 = 2;
   localparam int SWB_BASE_A2 = 7;

   // A switch closed (ON) reads as 0
   localparam logic SW_ON = 1'b0;

   // Wait-state counts
   localparam logic [2:0] WAIT_ROM = 3'h5;
   localparam logic [2:0] WAIT_IO_A = 3'h2;
   localparam logic [2:0] WAIT_IO_B = 3'h3;
   localparam logic [2:0] WAIT_IO_NONE = 3'h4;

   // Wait jumper codes
   localparam logic [1:0] JMP_POS_A = 2'h1;
   localparam logic [1:0] JMP_POS_B = 2'h2;
   localparam logic [1:0] JMP_REMOVED = 2'h0;

   // Boot window geometry and interrupt line count
   localparam int ROM_PAGE_BITS = 8;
   localparam int ADR_W = 24;
   localparam int ROM_ADR_W = 11;
   localparam int NUM_VI = 8;

   // Reset values
   localparam logic SER_MARK = 1'b0;
   localparam logic BOOT_ARMED = 1'b1;

   // Bus and strap pins, sampled through the synchroniser
   typedef struct packed {
      logic [ADR_W-1:0] adr;
      logic [7:0] dout;
      logic smemr;
      logic sinp;
      logic sout;
      logic pdbin;
      logic pwr_n;
      logic bus_cycle;
      logic fdc_irq;
      logic serial_in;
      logic [7:0] option_switch_bank_a;
      logic [7:0] option_switch_bank_b;
      logic [1:0] io_wait_count_jumper;
      logic boot_half_select_jumper;
      logic [NUM_VI-1:0] vi_jumper;
      logic general_irq_jumper;
   } pins_s;

   // Open-drain interrupt drive
   typedef struct packed {
      logic [NUM_VI-1:0] vi_out;
      logic [NUM_VI-1:0] vi_oe;
      logic int_out;
      logic int_oe;
   } irq_drive_s;

   // Registered module state
   typedef struct packed {
      logic serial_ff;
      logic boot_ff;
      logic strobe_ff;
      logic waiting;
      logic [2:0] wait_cnt;
      logic [7:0] di_data;
      logic di_oe;
   } state_s;

endpackage : boot_opt_pkg

// [rtl/pin_sync.sv]
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes the caller reads only the second stage.
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : pin_sync

// [rtl/boot_option_logic.sv]
// Bus-side option logic: status poll, interrupt routing, boot overlay,
// wait states, arbitration priority and serial/motor latch.
// Assumes bus pins and straps are asynchronous and system RAM honours phantom.
`timescale 1ns/100ps
module boot_option_logic
   import boot_opt_pkg::*;
#(
   parameter logic [ADR_W-1:0] RESET_ADDR = 24'h000000
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADR_W-1:0] adr,
   input wire logic [7:0] dout,
   input wire logic smemr,
   input wire logic sinp,
   input wire logic sout,
   input wire logic pdbin,
   input wire logic pwr_n,
   input wire logic bus_cycle,
   input wire logic fdc_irq,
   input wire logic serial_in,
   input wire logic [7:0] rom_data,
   input wire logic [7:0] option_switch_bank_a,
   input wire logic [7:0] option_switch_bank_b,
   input wire logic [1:0] io_wait_count_jumper,
   input wire logic boot_half_select_jumper,
   input wire logic [NUM_VI-1:0] vi_jumper,
   input wire logic general_irq_jumper,
   output logic [7:0] di_data,
   output logic di_oe,
   output logic [ROM_ADR_W-1:0] rom_addr,
   output logic phantom_n,
   output logic wait_n,
   output logic fdc_sel,
   output logic [NUM_VI-1:0] vi_out,
   output logic [NUM_VI-1:0] vi_oe,
   output logic int_out,
   output logic int_oe,
   output logic [3:0] dma_priority,
   output logic serial_out,
   output logic motor_on
);

   pins_s pin_raw;
   pins_s p;
   state_s cur_ff;
   state_s nxt_cur;
   irq_drive_s irq;
   logic boot_live;
   logic io_sel;
   logic rom_sel;
   logic strobe;
   logic strobe_rise;
   logic [2:0] wait_need;
   logic [5:0] base_adr;

   // Lowest set jumper wins, so only one line is ever driven
   function automatic logic [NUM_VI-1:0] first_set(input logic [NUM_VI-1:0] v);
      logic [NUM_VI-1:0] r;
      r = '0;
      for (int i = NUM_VI - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction : first_set

   // Relative port of the four-port block under decode
   function automatic logic at_port(input logic [1:0] a, input logic [1:0] port);
      return a == port;
   endfunction : at_port

   // Bus pins and straps gathered for synchronising
   assign pin_raw = '{adr: adr, dout: dout, smemr: smemr, sinp: sinp, sout: sout,
                      pdbin: pdbin, pwr_n: pwr_n, bus_cycle: bus_cycle,
                      fdc_irq: fdc_irq, serial_in: serial_in,
                      option_switch_bank_a: option_switch_bank_a,
                      option_switch_bank_b: option_switch_bank_b,
                      io_wait_count_jumper: io_wait_count_jumper,
                      boot_half_select_jumper: boot_half_select_jumper,
                      vi_jumper: vi_jumper, general_irq_jumper: general_irq_jumper};

   pin_sync #(.W($bits(pins_s))) u_sync (
      .clk(clk),
      .srst(srst),
      .d(pin_raw),
      .q(p)
   );

   // Address decode and strobes
   always_comb begin
      // Base switches run from A7 at position 3 down to A2 at position 8
      base_adr = '0;
      for (int k = 0; k <= SWB_BASE_A2 - SWB_BASE_A7; k++) begin
         base_adr[k] = p.option_switch_bank_b[SWB_BASE_A2 - k];
      end
      boot_live = cur_ff.boot_ff &&
                  (p.option_switch_bank_a[SWA_BOOT_INH] != SW_ON);
      io_sel = (p.sinp || p.sout) && !p.bus_cycle &&
               (p.adr[7:2] == base_adr);
      rom_sel = boot_live && p.smemr && !p.bus_cycle &&
                (p.adr[ADR_W-1:ROM_PAGE_BITS] ==
                 RESET_ADDR[ADR_W-1:ROM_PAGE_BITS]);
      strobe = p.pdbin || !p.pwr_n;
      strobe_rise = strobe && !cur_ff.strobe_ff;
   end

   // Wait count per cycle kind
   always_comb begin
      if (rom_sel) begin
         wait_need = WAIT_ROM;
      end else begin
         unique case (p.io_wait_count_jumper)
            JMP_POS_A: wait_need = WAIT_IO_A;
            JMP_POS_B: wait_need = WAIT_IO_B;
            JMP_REMOVED: wait_need = WAIT_IO_NONE;
            default: wait_need = WAIT_IO_A;
         endcase
      end
   end

   // Next-state logic
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.strobe_ff = strobe;
      // Wait-state counter, armed at strobe start
      if (cur_ff.waiting) begin
         nxt_cur.wait_cnt = cur_ff.wait_cnt - 3'h1;
         nxt_cur.waiting = (cur_ff.wait_cnt != 3'h1);
      end else if (strobe_rise && (p.option_switch_bank_a[SWA_WAIT_EN] == SW_ON) &&
                   (rom_sel || io_sel || p.bus_cycle)) begin
         nxt_cur.waiting = 1'b1;
         nxt_cur.wait_cnt = wait_need;
      end
      // Serial port write, once per strobe
      if (strobe_rise && !p.pwr_n && io_sel && p.sout &&
          at_port(p.adr[1:0], PORT_SERIAL)) begin
         nxt_cur.serial_ff = p.dout[BIT_SER];
         if (p.dout[BIT_BOOT_KEEP] == 1'b0) begin
            nxt_cur.boot_ff = 1'b0;
         end
      end
      // Read data for the bus
      nxt_cur.di_oe = p.pdbin && (rom_sel || (io_sel && p.sinp &&
                      (at_port(p.adr[1:0], PORT_STATUS) || at_port(p.adr[1:0], PORT_SERIAL))));
      nxt_cur.di_data = 8'h00;
      if (rom_sel) begin
         nxt_cur.di_data = rom_data;
      end else if (at_port(p.adr[1:0], PORT_STATUS)) begin
         nxt_cur.di_data[BIT_IRQ] = p.fdc_irq;
      end else if (at_port(p.adr[1:0], PORT_SERIAL)) begin
         nxt_cur.di_data[BIT_SER] = p.serial_in;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ff <= '0;
         cur_ff.serial_ff <= SER_MARK;
         cur_ff.boot_ff <= BOOT_ARMED;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Interrupt steering onto one open-drain line
   always_comb begin
      irq.vi_out = '0;
      irq.int_out = 1'b0;
      irq.int_oe = p.fdc_irq && p.general_irq_jumper;
      irq.vi_oe = (p.fdc_irq && !p.general_irq_jumper) ?
                  first_set(p.vi_jumper) : '0;
   end

   // Outputs
   assign vi_out = irq.vi_out;
   assign vi_oe = irq.vi_oe;
   assign int_out = irq.int_out;
   assign int_oe = irq.int_oe;
   assign di_data = cur_ff.di_data;
   assign di_oe = cur_ff.di_oe;
   assign wait_n = !cur_ff.waiting;
   assign fdc_sel = io_sel && (at_port(p.adr[1:0], PORT_FDC_MSR) ||
                               at_port(p.adr[1:0], PORT_FDC_DATA));
   assign phantom_n = !(boot_live && !p.bus_cycle);
   assign rom_addr = {p.boot_half_select_jumper,
                      p.option_switch_bank_b[SWB_ROUT_HI],
                      p.option_switch_bank_b[SWB_ROUT_LO],
                      p.adr[ROM_PAGE_BITS-1:0]};
   assign dma_priority = {p.option_switch_bank_a[SWA_PRIO3],
                          p.option_switch_bank_a[SWA_PRIO2],
                          p.option_switch_bank_a[SWA_PRIO1],
                          p.option_switch_bank_a[SWA_PRIO0]};
   assign serial_out = cur_ff.serial_ff;
   assign motor_on = (p.option_switch_bank_a[SWA_MOTOR_CTL] == SW_ON) ?
                     !cur_ff.serial_ff : 1'b1;

endmodule : boot_option_logic

// [tb/boot_checks_props.sv]
// Checker for the bus-side option logic, bound onto its top module.
// Assumes pins reach outputs through a two-stage synchroniser.
`timescale 1ns/100ps
module boot_checks
   import boot_opt_pkg::*;
(
   input logic clk,
   input logic srst,
   input logic [ADR_W-1:0] adr,
   input logic pdbin,
   input logic pwr_n,
   input logic sinp,
   input logic sout,
   input logic bus_cycle,
   input logic [7:0] option_switch_bank_a,
   input logic [7:0] option_switch_bank_b,
   input logic boot_half_select_jumper,
   input logic [ROM_ADR_W-1:0] rom_addr,
   input logic phantom_n,
   input logic wait_n,
   input logic fdc_sel,
   input logic [NUM_VI-1:0] vi_out,
   input logic [NUM_VI-1:0] vi_oe,
   input logic int_out,
   input logic int_oe,
   input logic [3:0] dma_priority,
   input logic serial_out,
   input logic motor_on
);
   logic [1:0] run_ff;
   logic [2:0] low_ff;
   logic [7:0] sw;
   logic strb;
   logic [5:0] base;
   assign sw = option_switch_bank_a;
   // Base address from switch positions 3 to 8, A7 first
   assign base = {option_switch_bank_b[2], option_switch_bank_b[3], option_switch_bank_b[4],
                  option_switch_bank_b[5], option_switch_bank_b[6], option_switch_bank_b[7]};
   assign strb = pdbin | ~pwr_n;
   // Cycles since reset and length of the running wait
   always_ff @(posedge clk) begin
      if (srst) begin
         run_ff <= 2'h0;
         low_ff <= 3'h0;
      end else begin
         run_ff <= (run_ff == 2'h3) ? run_ff : run_ff + 2'h1;
         low_ff <= wait_n ? 3'h0 : low_ff + 3'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Straps and address held long enough to pass the synchroniser
   sequence settled;
      (run_ff == 2'h3 && $stable({sw, option_switch_bank_b, boot_half_select_jumper, adr}))[*3];
   endsequence
   // Port strobes, base switches and address held past the synchroniser
   sequence quiet;
      (run_ff == 2'h3 && $stable({sinp, sout, bus_cycle, option_switch_bank_b, adr}))[*3];
   endsequence
   fdc_pick_a: assert property (quiet |-> fdc_sel == ((sinp || sout) && !bus_cycle &&
      adr[7:2] == base && !adr[1]))
      else $error("controller select mismatch");
   prio_map_a: assert property (settled |-> dma_priority == {sw[4], sw[5], sw[6], sw[7]})
      else $error("priority mismatch");
   rom_addr_a: assert property (settled |-> rom_addr ==
      {boot_half_select_jumper, option_switch_bank_b[0], option_switch_bank_b[1], adr[7:0]})
      else $error("rom address mismatch");
   motor_map_a: assert property (settled |-> motor_on == ((sw[2] == SW_ON) ? !serial_out : 1'b1))
      else $error("motor line mismatch");
   boot_inhibit_a: assert property (settled ##0 sw[3] == SW_ON |-> phantom_n)
      else $error("phantom while inhibited");
   one_line_a: assert property ($onehot0({vi_oe, int_oe}) && vi_out == '0 && !int_out)
      else $error("interrupt drive mismatch");
   wait_len_a: assert property ($rose(wait_n) |-> low_ff inside {[2:5]})
      else $error("wait length out of range");
   wait_gate_a: assert property (settled ##0 sw[0] != SW_ON |-> !$fell(wait_n))
      else $error("wait while disabled");
   wait_cause_a: assert property ($fell(wait_n) |-> $past(strb, 2) || $past(strb, 3))
      else $error("wait without strobe");
endmodule : boot_checks
bind boot_option_logic boot_checks u_chk (.clk(clk), .srst(srst), .adr(adr), .pdbin(pdbin),
   .pwr_n(pwr_n), .sinp(sinp), .sout(sout), .bus_cycle(bus_cycle), .fdc_sel(fdc_sel),
   .option_switch_bank_a(option_switch_bank_a),
   .option_switch_bank_b(option_switch_bank_b), .boot_half_select_jumper(boot_half_select_jumper),
   .rom_addr(rom_addr), .phantom_n(phantom_n), .wait_n(wait_n), .vi_out(vi_out), .vi_oe(vi_oe),
   .int_out(int_out), .int_oe(int_oe), .dma_priority(dma_priority), .serial_out(serial_out),
   .motor_on(motor_on));

// [tb/host_model.sv]
// Host bus master with system memory that stands aside under phantom.
// Assumes board outputs settle within 1 ns of the clock edge.
`timescale 1ns/100ps
module host_model
   import boot_opt_pkg::*;
(
   input logic clk,
   input logic wait_n,
   input logic phantom_n,
   input logic [7:0] di_data,
   input logic di_oe,
   output logic [ADR_W-1:0] adr,
   output logic [7:0] dout,
   output logic [5:0] ctl
);
   // Bus idle at time zero: status low, write strobe high
   initial begin
      {adr, dout} = '0;
      ctl = 6'h01;
   end
   // One cycle held until wait ends; nw of 99 marks a hang
   task automatic xfer(input logic [3:0] st, input logic wr, input logic [ADR_W-1:0] a,
      input logic [7:0] d, output logic [7:0] rd, output int nw);
      int i;
      nw = 0;
      {adr, dout, ctl} = {a, d, st, ~wr, ~wr};
      for (i = 0; i < 12 && (i < 5 || !wait_n); i++) begin
         @(posedge clk);
         #1;
         nw += int'(!wait_n);
      end
      // Board drives when enabled, else unphantomed memory, else lines float high
      rd = di_oe ? di_data : (st[3] && phantom_n) ? ~a[7:0] : 8'hFF;
      if (i == 12) nw = 99;
      {adr, dout, ctl} = {~a, ~d, 6'h01};
      repeat (3) @(posedge clk);
      #1;
   endtask : xfer
endmodule : host_model

// [tb/tb_top.sv]
// Self-checking bench for the bus-side option logic with a host model.
// Assumes a page-unaligned reset address and base port C0.
`timescale 1ns/100ps
module tb_top
   import boot_opt_pkg::*;
;
   localparam logic [ADR_W-1:0] RST_A = 24'hFFFFF0;
   logic clk, srst, fdc_irq, half, gen_j, phantom_n, wait_n, int_oe, serial_out, motor_on;
   logic di_oe, ser_in;
   logic [ADR_W-1:0] adr;
   logic [7:0] dout, di_data, rom_data, sw_a, sw_b, vi_j, vi_oe, rd, lo;
   logic [5:0] ctl;
   logic [1:0] wj;
   logic [3:0] prio;
   logic [ROM_ADR_W-1:0] rom_addr;
   int fails, checked, nw, j;
   host_model host (.clk(clk), .wait_n(wait_n), .phantom_n(phantom_n), .di_data(di_data),
      .di_oe(di_oe), .adr(adr), .dout(dout), .ctl(ctl));
   boot_option_logic #(.RESET_ADDR(RST_A)) uut (.clk(clk), .srst(srst), .adr(adr), .dout(dout),
      .smemr(ctl[5]), .sinp(ctl[4]), .sout(ctl[3]), .bus_cycle(ctl[2]), .pdbin(ctl[1]),
      .pwr_n(ctl[0]), .fdc_irq(fdc_irq), .serial_in(ser_in), .rom_data(rom_data),
      .option_switch_bank_a(sw_a), .option_switch_bank_b(sw_b), .io_wait_count_jumper(wj),
      .boot_half_select_jumper(half), .vi_jumper(vi_j), .general_irq_jumper(gen_j),
      .di_data(di_data), .di_oe(di_oe), .rom_addr(rom_addr), .phantom_n(phantom_n),
      .wait_n(wait_n), .fdc_sel(), .vi_out(), .vi_oe(vi_oe), .int_out(), .int_oe(int_oe),
      .dma_priority(prio), .serial_out(serial_out), .motor_on(motor_on));
   // Boot ROM contents as a function of its address
   function automatic logic [7:0] romf(input logic [10:0] a);
      return a[7:0] ^ {a[10:8], 5'h0B};
   endfunction : romf
   assign rom_data = romf(rom_addr);
   // Expected waits per jumper code
   function automatic logic [2:0] io_waits(input logic [1:0] c);
      return (c == 2'h2) ? 3'h3 : (c == 2'h0) ? 3'h4 : 3'h2;
   endfunction : io_waits
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   task automatic bus(input logic [3:0] st, input logic wr, input logic [23:0] a, input logic [7:0] d);
      host.xfer(st, wr, a, d, rd, nw);
      if (nw == 99) begin
         fails++;
         final_report();
      end
   endtask : bus
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Main sequence
   initial begin
      void'($urandom(32'h105F));
      {srst, fdc_irq, half, gen_j, vi_j, wj, sw_a, sw_b} = {4'h8, 8'h00, 2'h1, 8'hFF, 8'h0C};
      ser_in = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      srst = 1'b0;
      settle();
      check(serial_out, SER_MARK);
      for (j = 0; j < 6; j++) begin
         sw_a = (j == 0) ? 8'h0F : (j == 1) ? 8'hF0 : 8'($urandom);
         settle();
         check(prio, 8 * sw_a[4] + 4 * sw_a[5] + 2 * sw_a[6] + sw_a[7]);
      end
      sw_a = 8'hFE;
      for (j = 0; j <= NUM_VI; j++) begin
         {gen_j, vi_j, fdc_irq} = {j == NUM_VI, (j < NUM_VI) ? 8'(1 << j) : 8'($urandom), 1'b1};
         settle();
         check({int_oe, vi_oe}, (j == NUM_VI) ? 9'h100 : 9'(1 << j));
         bus(4'h4, 1'b0, 24'hC2, 8'h00);
         check(rd[7], 1'b1);
         fdc_irq = 1'b0;
         settle();
         check({int_oe, vi_oe}, 9'h000);
         bus(4'h4, 1'b0, 24'hC2, 8'h00);
         check(rd[7], 1'b0);
      end
      for (j = 0; j < 4; j++) begin
         wj = 2'(j);
         bus((j == 3) ? 4'h4 : 4'h1, 1'b0, (j == 3) ? 24'h10 : 24'($urandom), 8'h00);
         check(nw, (j == 3) ? 3'h0 : io_waits(wj));
      end
      bus(4'h4, 1'b0, 24'hC1, 8'h00);
      check(nw, io_waits(wj));
      for (j = 0; j < 8; j++) begin
         {half, sw_b[0], sw_b[1]} = 3'(j);
         lo = (j == 0) ? 8'h00 : (j == 7) ? 8'hFF : 8'($urandom);
         settle();
         check(phantom_n, 1'b0);
         bus(4'h8, 1'b0, {RST_A[23:8], lo}, 8'h00);
         check({rd, 5'(nw)}, {romf({3'(j), lo}), 5'h5});
      end
      bus(4'h8, 1'b0, {~RST_A[23:8], lo}, 8'h00);
      check(nw, 0);
      sw_a = 8'hFA;
      bus(4'h2, 1'b1, 24'hC3, 8'h01);
      check({serial_out, motor_on, phantom_n, 3'(nw)}, {3'h2, io_waits(wj)});
      bus(4'h2, 1'b1, 24'hC3, 8'h80);
      check({serial_out, motor_on, phantom_n}, 3'h5);
      sw_a = 8'hFE;
      settle();
      check(motor_on, 1'b1);
      sw_a = 8'hFA;
      bus(4'h2, 1'b1, 24'hC3, 8'h7F);
      check({serial_out, motor_on}, 2'h1);
      bus(4'h8, 1'b0, RST_A, 8'h00);
      check({rd, 5'(nw)}, {~RST_A[7:0], 5'h0});
      for (j = 0; j < 2; j++) begin
         ser_in = j[0];
         bus(4'h4, 1'b0, 24'hC3, 8'h00);
         check(rd[7], ser_in);
      end
      srst = 1'b1;
      settle();
      srst = 1'b0;
      settle();
      check({phantom_n, serial_out}, 2'h0);
      sw_a = 8'hF6;
      settle();
      bus(4'h8, 1'b0, RST_A, 8'h00);
      check({phantom_n, 3'(nw)}, 4'h8);
      final_report();
   end
endmodule : tb_top
